// >>> design/ephh_pkg.sv
package ephh_pkg;

	// register map of the software bus, byte addresses
	localparam logic [7:0] ADDR_NODE = 8'h00;
	localparam logic [7:0] ADDR_CONF = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;

	// reset values
	localparam logic [5:0] RST_NODE_NUMBER = 6'h3f;
	localparam logic [5:0] RST_GAP_COUNT   = 6'h3f;
	localparam logic [2:0] RST_PWR         = 3'h0;

	// conf register fields
	localparam int CONF_GAP_LSB    = 0;
	localparam int CONF_FROOT_BIT  = 6;
	localparam int CONF_LINK_BIT   = 7;
	localparam int CONF_CONT_BIT   = 8;
	localparam int CONF_PWR_LSB    = 9;

	// stat register fields
	localparam int STAT_FAULT_LSB  = 0;
	localparam int STAT_DIS_LSB    = 8;
	localparam int STAT_SUSP_LSB   = 16;
	localparam int STAT_DROP_BIT   = 24;
	localparam int STAT_BUSY_BIT   = 25;

	// phy packet quadlet fields
	localparam int PKT_ID_LSB    = 30;
	localparam int PKT_NODE_LSB  = 24;
	localparam int PKT_R_BIT     = 23;
	localparam int PKT_T_BIT     = 22;
	localparam int PKT_TYPE_LSB  = 18;
	localparam int PKT_PAGE_LSB  = 15;
	localparam int PKT_PORT_LSB  = 11;
	localparam int PKT_REG_LSB   = 8;
	localparam int PKT_DATA_LSB  = 0;
	localparam int PKT_CMND_LSB  = 0;
	localparam int PKT_OK_BIT    = 3;
	localparam int PKT_D_BIT     = 4;
	localparam int PKT_B_BIT     = 5;
	localparam int PKT_C_BIT     = 6;
	localparam int PKT_F_BIT     = 7;

	localparam logic [1:0] PKT_ID_CONFIG = 2'h0;
	localparam logic [1:0] PKT_ID_SELFID = 2'h2;

	// extended packet types
	localparam logic [3:0] TYPE_PING     = 4'h0;
	localparam logic [3:0] TYPE_RD_BASE  = 4'h1;
	localparam logic [3:0] TYPE_RPL_BASE = 4'h3;
	localparam logic [3:0] TYPE_RD_PAGE  = 4'h5;
	localparam logic [3:0] TYPE_RPL_PAGE = 4'h7;
	localparam logic [3:0] TYPE_CMD      = 4'h8;
	localparam logic [3:0] TYPE_CONFIRM  = 4'ha;
	localparam logic [3:0] TYPE_RESUME   = 4'hf;

	// remote command codes
	localparam logic [2:0] CMD_NOP     = 3'h0;
	localparam logic [2:0] CMD_DISABLE = 3'h1;
	localparam logic [2:0] CMD_SUSPEND = 3'h2;
	localparam logic [2:0] CMD_CLRFLT  = 3'h4;
	localparam logic [2:0] CMD_ENABLE  = 3'h5;
	localparam logic [2:0] CMD_RESUME  = 3'h6;

	// paged register address offset, and self-id constants
	localparam logic [3:0] PAGED_BASE  = 4'h8;
	localparam logic [1:0] SELFID_SP   = 2'h2;
	localparam logic [1:0] PSTAT_CONN  = 2'h3;
	localparam logic [1:0] PSTAT_NONE  = 2'h1;
	localparam logic [1:0] SPEED_S100  = 2'h0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} ephh_state_t;

endpackage

// >>> design/ephh_decode.sv
`timescale 1ns/1ns
module ephh_decode
	import ephh_pkg::*;
(
	// received packet
	input  wire logic [31:0] i_quad0,
	input  wire logic [31:0] i_quad1,
	input  wire logic [5:0]  i_node,
	// decoded fields
	output logic             o_ext,
	output logic             o_for_me,
	output logic [3:0]       o_ptype,
	output logic [2:0]       o_page,
	output logic [3:0]       o_port,
	output logic [2:0]       o_rsel,
	output logic [2:0]       o_cmnd
);

	wire intact;
	wire cfg_form;

	assign intact   = (i_quad1 == ~i_quad0);
	assign cfg_form = (i_quad0[PKT_ID_LSB +: 2] == PKT_ID_CONFIG);
	assign o_ext    = intact & cfg_form & ~i_quad0[PKT_R_BIT]
		& ~i_quad0[PKT_T_BIT];
	assign o_for_me = (i_quad0[PKT_NODE_LSB +: 6] == i_node);
	assign o_ptype  = i_quad0[PKT_TYPE_LSB +: 4];
	assign o_page   = i_quad0[PKT_PAGE_LSB +: 3];
	assign o_port   = i_quad0[PKT_PORT_LSB +: 4];
	assign o_rsel   = i_quad0[PKT_REG_LSB +: 3];
	assign o_cmnd   = i_quad0[PKT_CMND_LSB +: 3];

endmodule

// >>> design/ephh_top.sv
// Notes on behaviour
// - config-format packet with R and T both zero is an extended packet
// - extended packets never change force-root or gap count
// - type 0 is a ping for the node in the node-number field
// - ping to this node sends its self-id packet promptly (here dropped and flagged if tx is busy)
// - type 1 reads a base register, type 5 a paged register
// - paged address is 1000b plus reg field; base uses reg field
// - addressed read request is answered with a reply packet (here dropped and flagged if tx is busy)
// - reply type 3 or 7, own node, echoed page, port, reg
// - reply data holds the addressed register's current value
// - type 8 is a remote command for the given port
// - command 0 nop, 1 notify then disable, 2 suspend initiator
// - command 4 clears fault, 5 enables, 6 resumes the port
// - every remote command is answered with a confirmation (here dropped, flagged and not executed if tx is busy)
// - confirmation type A, own node, port and echoed command
// - confirmation flags are port fault, connected, bias, disable
// - ok flag is 1 when the command executes, else 0
// - type F is a broadcast resume packet
// - resume packet resumes every suspended port
// - packet is quadlet plus its inverse, checked on receive
// - all phy packets go out at the lowest speed
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ns
module ephh_top
	import ephh_pkg::*;
#(
	parameter int NPORTS = 3
) (
	// clock and reset
	input  wire logic              I_CLOCK,
	input  wire logic              I_NRST,
	// apb slave
	input  wire logic              I_PSEL,
	input  wire logic              I_PENABLE,
	input  wire logic              I_PWRITE,
	input  wire logic [7:0]        I_PADDR,
	input  wire logic [31:0]       I_PWDATA,
	output logic                   O_PREADY,
	output logic [31:0]            O_PRDATA,
	output logic                   O_PSLVERR,
	// received phy packets
	input  wire logic              I_RX_VALID,
	input  wire logic [31:0]       I_RX_QUAD0,
	input  wire logic [31:0]       I_RX_QUAD1,
	// transmitted phy packets
	output logic                   O_TX_VALID,
	output logic [31:0]            O_TX_QUAD0,
	output logic [31:0]            O_TX_QUAD1,
	output logic [1:0]             O_TX_SPEED,
	input  wire logic              I_TX_READY,
	// port status and control
	input  wire logic [NPORTS-1:0] I_PORT_CONNECTED,
	input  wire logic [NPORTS-1:0] I_PORT_BIAS,
	input  wire logic [NPORTS-1:0] I_PORT_FAULT,
	output logic [NPORTS-1:0]      O_PORT_DISABLED,
	output logic [NPORTS-1:0]      O_PORT_SUSPENDED,
	output logic [NPORTS-1:0]      O_PORT_RESUME,
	output logic [NPORTS-1:0]      O_PORT_TX_DIS_NOTIFY
);

	localparam int PAD = 16 - NPORTS;

	ephh_state_t state;
	ephh_state_t next_state;

	logic [5:0]        node_number;
	logic [5:0]        gap_count;
	logic              force_root;
	logic              link_active;
	logic              contender;
	logic [2:0]        pwr;
	logic              dropped;
	logic [NPORTS-1:0] fault;

	// decoded receive packet
	wire       dec_ext;
	wire       dec_for_me;
	wire [3:0] dec_ptype;
	wire [2:0] dec_page;
	wire [3:0] dec_port;
	wire [2:0] dec_rsel;
	wire [2:0] dec_cmnd;

	ephh_decode u_decode (
		.i_quad0  (I_RX_QUAD0),
		.i_quad1  (I_RX_QUAD1),
		.i_node   (node_number),
		.o_ext    (dec_ext),
		.o_for_me (dec_for_me),
		.o_ptype  (dec_ptype),
		.o_page   (dec_page),
		.o_port   (dec_port),
		.o_rsel   (dec_rsel),
		.o_cmnd   (dec_cmnd)
	);

	function automatic logic cmd_known(input logic [2:0] c);
		cmd_known = (c == CMD_NOP) || (c == CMD_DISABLE)
			|| (c == CMD_SUSPEND) || (c == CMD_CLRFLT)
			|| (c == CMD_ENABLE) || (c == CMD_RESUME);
	endfunction

	// packet classification
	wire rx_ext;
	wire is_ping;
	wire is_read;
	wire is_page;
	wire is_cmd;
	wire is_resume;
	wire need_tx;
	wire take;

	assign rx_ext    = I_RX_VALID & dec_ext;
	assign is_ping   = rx_ext & dec_for_me & (dec_ptype == TYPE_PING);
	assign is_page   = (dec_ptype == TYPE_RD_PAGE);
	assign is_read   = rx_ext & dec_for_me
		& ((dec_ptype == TYPE_RD_BASE) | is_page);
	assign is_cmd    = rx_ext & dec_for_me & (dec_ptype == TYPE_CMD);
	assign is_resume = rx_ext & (dec_ptype == TYPE_RESUME);
	// other types fall through every decode above
	assign need_tx   = is_ping | is_read | is_cmd;
	assign take      = need_tx & (state == ST_IDLE);

	// padded port views for indexing by the 4-bit port field
	wire [15:0] pad_fault;
	wire [15:0] pad_conn;
	wire [15:0] pad_bias;
	wire [15:0] pad_dis;
	wire [15:0] pad_susp;
	wire        port_ok;

	assign pad_fault = {{PAD{1'b0}}, fault};
	assign pad_conn  = {{PAD{1'b0}}, I_PORT_CONNECTED};
	assign pad_bias  = {{PAD{1'b0}}, I_PORT_BIAS};
	assign pad_dis   = {{PAD{1'b0}}, O_PORT_DISABLED};
	assign pad_susp  = {{PAD{1'b0}}, O_PORT_SUSPENDED};
	assign port_ok   = ({28'h0, dec_port} < NPORTS);

	// register read for remote access
	wire [3:0] reg_addr;
	wire [7:0] base_val;
	wire [7:0] paged_val;
	wire [7:0] read_val;

	assign reg_addr  = is_page ? PAGED_BASE + {1'b0, dec_rsel}
		: {1'b0, dec_rsel};
	assign base_val  = (reg_addr == 4'h0) ? {node_number, 2'h0}
		: (reg_addr == 4'h1) ? {force_root, 1'b0, gap_count}
		: (reg_addr == 4'h2) ? 8'(NPORTS) : 8'h00;
	assign paged_val = (dec_page == 3'h0 && reg_addr == PAGED_BASE && port_ok)
		? {pad_fault[dec_port], pad_conn[dec_port], pad_bias[dec_port],
		   pad_dis[dec_port], pad_susp[dec_port], 3'h0} : 8'h00;
	assign read_val  = reg_addr[3] ? paged_val : base_val;

	// outgoing frames
	wire [11:0] port_sid;
	wire [31:0] selfid_q;
	wire [31:0] reply_q;
	wire [31:0] confirm_q;
	wire [31:0] frame_q;
	wire        cmd_ok;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sid
			if (g < NPORTS) begin : g_on
				assign port_sid[11-2*g -: 2] = I_PORT_CONNECTED[g]
					? PSTAT_CONN : PSTAT_NONE;
			end else begin : g_off
				assign port_sid[11-2*g -: 2] = 2'h0;
			end
		end
	endgenerate
	assign port_sid[5:0] = 6'h0;

	assign selfid_q  = {PKT_ID_SELFID, node_number, 1'b0, link_active,
		gap_count, SELFID_SP, 2'h0, contender, pwr, port_sid[11:6], 2'h0};
	assign reply_q   = {PKT_ID_CONFIG, node_number, 2'h0,
		is_page ? TYPE_RPL_PAGE : TYPE_RPL_BASE,
		dec_page, dec_port, dec_rsel, read_val};
	assign cmd_ok    = cmd_known(dec_cmnd) & port_ok;
	assign confirm_q = {PKT_ID_CONFIG, node_number, 2'h0, TYPE_CONFIRM,
		3'h0, dec_port, 3'h0,
		pad_fault[dec_port], pad_conn[dec_port],
		pad_bias[dec_port], pad_dis[dec_port],
		cmd_ok, dec_cmnd};
	assign frame_q   = is_ping ? selfid_q
		: is_read ? reply_q
		: confirm_q;

	// transmit state
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: if (take) next_state = ST_SEND;
			ST_SEND: if (I_TX_READY) next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			state      <= ST_IDLE;
			O_TX_VALID <= 1'b0;
			O_TX_QUAD0 <= 32'h0;
			O_TX_QUAD1 <= 32'h0;
			O_TX_SPEED <= SPEED_S100;
		end else begin
			state      <= next_state;
			O_TX_VALID <= (next_state == ST_SEND);
			O_TX_SPEED <= SPEED_S100;
			if (take) begin
				O_TX_QUAD0 <= frame_q;
				O_TX_QUAD1 <= ~frame_q;
			end
		end
	end

	// apb slave, no wait states
	wire apb_setup;
	wire apb_wr;
	wire hit_node;
	wire hit_conf;
	wire hit_stat;
	wire [31:0] stat_val;
	wire [31:0] rd_val;

	assign apb_setup = I_PSEL & ~I_PENABLE;
	assign apb_wr    = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
	assign hit_node  = (I_PADDR == ADDR_NODE);
	assign hit_conf  = (I_PADDR == ADDR_CONF);
	assign hit_stat  = (I_PADDR == ADDR_STAT);
	assign stat_val  = {6'h0, (state == ST_SEND), dropped,
		{(8-NPORTS){1'b0}}, O_PORT_SUSPENDED,
		{(8-NPORTS){1'b0}}, O_PORT_DISABLED,
		{(8-NPORTS){1'b0}}, fault};
	assign rd_val    = hit_node ? {26'h0, node_number}
		: hit_conf ? {20'h0, pwr, contender, link_active,
			force_root, gap_count}
		: hit_stat ? stat_val : 32'h0;

	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_PREADY  <= 1'b0;
			O_PRDATA  <= 32'h0;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY  <= apb_setup;
			O_PRDATA  <= apb_setup & ~I_PWRITE ? rd_val : 32'h0;
			O_PSLVERR <= apb_setup & ~(hit_node | hit_conf | hit_stat);
		end
	end

	// configuration, written only by software
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			node_number <= RST_NODE_NUMBER;
			gap_count   <= RST_GAP_COUNT;
			force_root  <= 1'b0;
			link_active <= 1'b0;
			contender   <= 1'b0;
			pwr         <= RST_PWR;
		end else begin
			if (apb_wr && hit_node)
				node_number <= I_PWDATA[5:0];
			// packets never reach these fields
			if (apb_wr && hit_conf) begin
				gap_count   <= I_PWDATA[CONF_GAP_LSB +: 6];
				force_root  <= I_PWDATA[CONF_FROOT_BIT];
				link_active <= I_PWDATA[CONF_LINK_BIT];
				contender   <= I_PWDATA[CONF_CONT_BIT];
				pwr         <= I_PWDATA[CONF_PWR_LSB +: 3];
			end
		end
	end

	// dropped request flag, set wins over clear
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST)
			dropped <= 1'b0;
		else
			dropped <= (need_tx & (state != ST_IDLE))
				| (dropped & ~(apb_wr & hit_stat & I_PWDATA[STAT_DROP_BIT]));
	end

	// per-port command execution
	wire cmd_take;
	assign cmd_take = take & is_cmd;

	generate
		for (g = 0; g < NPORTS; g++) begin : g_port
			wire hit;
			wire clr_fault;
			wire do_resume;

			assign hit       = cmd_take & (dec_port == 4'(g));
			assign clr_fault = (hit & (dec_cmnd == CMD_CLRFLT))
				| (apb_wr & hit_stat & I_PWDATA[STAT_FAULT_LSB + g]);
			assign do_resume = (hit & (dec_cmnd == CMD_RESUME))
				| is_resume;

			always_ff @(posedge I_CLOCK or negedge I_NRST) begin
				if (!I_NRST) begin
					fault[g]                <= 1'b0;
					O_PORT_DISABLED[g]      <= 1'b0;
					O_PORT_SUSPENDED[g]     <= 1'b0;
					O_PORT_RESUME[g]        <= 1'b0;
					O_PORT_TX_DIS_NOTIFY[g] <= 1'b0;
				end else begin
					fault[g] <= I_PORT_FAULT[g] | (fault[g] & ~clr_fault);
					O_PORT_TX_DIS_NOTIFY[g] <= hit
						& (dec_cmnd == CMD_DISABLE);
					if (O_PORT_TX_DIS_NOTIFY[g])
						O_PORT_DISABLED[g] <= 1'b1;
					else if (hit && dec_cmnd == CMD_ENABLE)
						O_PORT_DISABLED[g] <= 1'b0;
					if (do_resume)
						O_PORT_SUSPENDED[g] <= 1'b0;
					else if (hit && dec_cmnd == CMD_SUSPEND)
						O_PORT_SUSPENDED[g] <= 1'b1;
					O_PORT_RESUME[g] <= do_resume & O_PORT_SUSPENDED[g];
				end
			end
		end
	endgenerate

	// checks
	sequence s_take_ping;
		take && is_ping;
	endsequence
	sequence s_take_read;
		take && is_read;
	endsequence
	sequence s_take_cmd;
		take && is_cmd;
	endsequence

	a_ping_selfid: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		s_take_ping |=> O_TX_VALID
			&& O_TX_QUAD0[PKT_ID_LSB +: 2] == PKT_ID_SELFID)
		else $error("ping not answered by self-id");
	a_reply_type: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		s_take_read |=> O_TX_QUAD0[PKT_TYPE_LSB +: 4]
			== ($past(is_page) ? TYPE_RPL_PAGE : TYPE_RPL_BASE))
		else $error("reply type wrong");
	a_reply_echo: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		s_take_read |=> O_TX_QUAD0[PKT_REG_LSB +: 10]
			== $past(I_RX_QUAD0[PKT_REG_LSB +: 10])
			&& O_TX_QUAD0[PKT_NODE_LSB +: 6] == node_number)
		else $error("reply echo or node wrong");
	a_confirm_ok: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		s_take_cmd |=> O_TX_QUAD0[PKT_TYPE_LSB +: 4] == TYPE_CONFIRM
			&& O_TX_QUAD0[PKT_OK_BIT] == $past(cmd_ok))
		else $error("confirmation type or ok wrong");
	a_foreign_ignored: assert property (@(posedge I_CLOCK)
		disable iff (!I_NRST)
		I_RX_VALID && !dec_for_me && state == ST_IDLE |=> !O_TX_VALID)
		else $error("packet for another node answered");
	a_ext_keeps_conf: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		rx_ext && !apb_wr |=> $stable(gap_count) && $stable(force_root))
		else $error("extended packet changed config");
	a_resume_all: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		is_resume |=> O_PORT_SUSPENDED == '0
			&& O_PORT_RESUME == $past(O_PORT_SUSPENDED))
		else $error("resume left a port suspended");
	a_notify_disable: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		O_PORT_TX_DIS_NOTIFY != '0 |=> (O_PORT_DISABLED
			& $past(O_PORT_TX_DIS_NOTIFY)) == $past(O_PORT_TX_DIS_NOTIFY))
		else $error("port not disabled after notify");
	a_tx_inverse: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		O_TX_VALID |-> O_TX_QUAD1 == ~O_TX_QUAD0 && O_TX_SPEED == SPEED_S100)
		else $error("bad frame or speed");

endmodule

// >>> tb/ephh_remote.sv
`timescale 1ns/1ns
module ephh_remote (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_nrst,
	// sink pacing
	input  wire logic        i_slow,
	// packets towards the node
	output logic             o_rx_valid,
	output logic [31:0]      o_rx_quad0,
	output logic [31:0]      o_rx_quad1,
	// packets from the node
	input  wire logic        i_tx_valid,
	input  wire logic [31:0] i_tx_quad0,
	input  wire logic [31:0] i_tx_quad1,
	input  wire logic [1:0]  i_tx_speed,
	output logic             o_tx_ready
);
	logic [31:0] got_q0;
	logic        got_inv;
	logic [1:0]  got_spd;
	logic [3:0]  got_lat;
	int          got_count;
	logic [3:0]  age;
	logic [1:0]  wcnt;

	initial begin
		o_rx_valid = 1'b0;
		o_rx_quad0 = 32'h0;
		o_rx_quad1 = 32'hffffffff;
	end

	// bad flips one bit of the inverse copy
	task automatic send(input logic [31:0] q, input logic bad);
		@(posedge i_clock);
		o_rx_valid <= 1'b1;
		o_rx_quad0 <= q;
		o_rx_quad1 <= ~q ^ {31'h0, bad};
		@(posedge i_clock);
		o_rx_valid <= 1'b0;
		o_rx_quad0 <= ~q;
		o_rx_quad1 <= q;
	endtask

	// slow sink raises ready for one cycle after a wait
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			got_count <= 0;
			o_tx_ready <= 1'b0;
			wcnt <= 2'h0;
			age <= 4'h0;
		end else begin
			age <= o_rx_valid ? 4'h0 : age + 4'h1;
			o_tx_ready <= !i_slow
				|| (i_tx_valid && !o_tx_ready && wcnt == 2'h2);
			if (i_tx_valid && o_tx_ready) begin
				got_q0 <= i_tx_quad0;
				got_inv <= (i_tx_quad1 === ~i_tx_quad0);
				got_spd <= i_tx_speed;
				got_lat <= age + 4'h1;
				got_count <= got_count + 1;
				wcnt <= 2'h0;
			end else if (i_tx_valid) begin
				wcnt <= wcnt + 2'h1;
			end
		end
	end
endmodule

// >>> tb/ephh_top_tb.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("BAD %s exp %h got %h", nm, exp, got); \
	end \
end
module ephh_top_tb
	import ephh_pkg::*;
;
	localparam int NP = 3;
	logic        clock, nrst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rx_q0, rx_q1, tx_q0, tx_q1, rd;
	logic        rx_valid, tx_valid, tx_ready, slow, err;
	logic [1:0]  tx_speed;
	logic [2:0]  conn, bias, fault, dis, sus, res, ntf;
	logic [2:0]  e_flt, e_dis, e_sus, e_ntf, e_res, acc_ntf, acc_res;
	logic [7:0]  bv [4] = '{8'h14, 8'h92, 8'h03, 8'h00};
	int          n_mismatch, tests_run, base;

	ephh_top #(.NPORTS(NP)) dut (
		.I_CLOCK(clock), .I_NRST(nrst), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata),
		.O_PSLVERR(pslverr), .I_RX_VALID(rx_valid), .I_RX_QUAD0(rx_q0),
		.I_RX_QUAD1(rx_q1), .O_TX_VALID(tx_valid), .O_TX_QUAD0(tx_q0),
		.O_TX_QUAD1(tx_q1), .O_TX_SPEED(tx_speed), .I_TX_READY(tx_ready),
		.I_PORT_CONNECTED(conn), .I_PORT_BIAS(bias),
		.I_PORT_FAULT(fault), .O_PORT_DISABLED(dis),
		.O_PORT_SUSPENDED(sus), .O_PORT_RESUME(res),
		.O_PORT_TX_DIS_NOTIFY(ntf)
	);
	ephh_remote rem (
		.i_clock(clock), .i_nrst(nrst), .i_slow(slow),
		.o_rx_valid(rx_valid), .o_rx_quad0(rx_q0), .o_rx_quad1(rx_q1),
		.i_tx_valid(tx_valid), .i_tx_quad0(tx_q0), .i_tx_quad1(tx_q1),
		.i_tx_speed(tx_speed), .o_tx_ready(tx_ready)
	);

	always #25 clock = ~clock;
	// sticky record of one-cycle pulses
	always @(posedge clock) begin
		acc_ntf <= nrst ? (acc_ntf | ntf) : 3'h0;
		acc_res <= nrst ? (acc_res | res) : 3'h0;
	end

	function automatic logic [31:0] pk(logic [5:0] n, logic [3:0] t,
		logic [2:0] pg, logic [3:0] pt, logic [2:0] rg, logic [7:0] lo);
		return {2'b00, n, 2'b00, t, pg, pt, rg, lo};
	endfunction
	function automatic logic [1:0] pf(logic c);
		return c ? PSTAT_CONN : PSTAT_NONE;
	endfunction

	task automatic tally_and_finish;
		if (n_mismatch == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask

	task automatic frame(input logic [31:0] exp, input string nm);
		int n;
		n = 0;
		while (rem.got_count == base && n < 30) begin
			@(posedge clock);
			n++;
		end
		if (rem.got_count == base) begin
			n_mismatch++;
			tally_and_finish();
		end else begin
			base = rem.got_count;
			`CHK(nm, exp, rem.got_q0)
			`CHK("inverse", 1'b1, rem.got_inv)
			`CHK("speed", SPEED_S100, rem.got_spd)
			if (!slow) `CHK("latency", 4'h1, rem.got_lat)
		end
	endtask

	task automatic quiet(input string nm);
		repeat (6) @(posedge clock);
		`CHK(nm, base, rem.got_count)
	endtask

	task automatic cmd(input logic [3:0] p, input logic [2:0] c);
		logic       ok;
		logic [3:0] st;
		ok = (p < NP) && (c != 3'h3) && (c != 3'h7);
		st = (p < NP) ? {e_flt[p], conn[p], bias[p], e_dis[p]} : 4'h0;
		rem.send(pk(6'h05, TYPE_CMD, 3'h0, p, 3'h0, {5'h0, c}), 1'b0);
		frame(pk(6'h05, TYPE_CONFIRM, 3'h0, p, 3'h0, {st, ok, c}),
			"confirm");
		if (ok) case (c)
			CMD_DISABLE: begin
				e_dis[p] = 1'b1;
				e_ntf[p] = 1'b1;
			end
			CMD_SUSPEND: e_sus[p] = 1'b1;
			CMD_CLRFLT:  e_flt[p] = 1'b0;
			CMD_ENABLE:  e_dis[p] = 1'b0;
			CMD_RESUME: begin
				e_res[p] = e_res[p] | e_sus[p];
				e_sus[p] = 1'b0;
			end
			default: ;
		endcase
		repeat (2) @(posedge clock);
		`CHK("disabled", e_dis, dis)
		`CHK("suspended", e_sus, sus)
		`CHK("notify", e_ntf, acc_ntf)
		`CHK("resume", e_res, acc_res)
		apb(1'b0, ADDR_STAT, 32'h0);
		`CHK("fault", e_flt, rd[2:0])
	endtask

	initial begin
		clock = 1'b0;
		nrst = 1'b0;
		{psel, penable, pwrite, slow} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		conn = 3'b101;
		bias = 3'b011;
		fault = 3'b000;
		{e_ntf, e_res, e_dis, e_sus} = 12'h0;
		e_flt = 3'b011;
		n_mismatch = 0;
		tests_run = 0;
		base = 0;
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		apb(1'b0, ADDR_NODE, 32'h0);
		`CHK("node reset", 32'h3f, rd)
		apb(1'b1, ADDR_NODE, 32'h5);
		apb(1'b1, ADDR_CONF, 32'h7d2);
		apb(1'b0, 8'h0c, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		@(posedge clock);
		fault <= 3'b011;
		@(posedge clock);
		fault <= 3'b000;
		rem.send(pk(6'h05, TYPE_PING, 3'h0, 4'h0, 3'h0, 8'h0), 1'b0);
		frame({PKT_ID_SELFID, 6'h05, 1'b0, 1'b1, 6'h12, SELFID_SP, 2'b00,
			1'b1, 3'h3, pf(conn[0]), pf(conn[1]), pf(conn[2]), 2'b00},
			"self id");
		rem.send(pk(6'h07, TYPE_PING, 3'h0, 4'h0, 3'h0, 8'h0), 1'b0);
		quiet("ping other");
		for (int r = 0; r < 4; r++) begin
			rem.send(pk(6'h05, TYPE_RD_BASE, 3'h0, 4'h0, r[2:0], 8'h0), 1'b0);
			frame(pk(6'h05, TYPE_RPL_BASE, 3'h0, 4'h0, r[2:0], bv[r]),
				"base reply");
		end
		rem.send(pk(6'h05, TYPE_RD_PAGE, 3'h0, 4'h1, 3'h0, 8'h0), 1'b0);
		frame(pk(6'h05, TYPE_RPL_PAGE, 3'h0, 4'h1, 3'h0, {e_flt[1],
			conn[1], bias[1], e_dis[1], e_sus[1], 3'h0}),
			"paged reply");
		for (int c = 0; c < 8; c++)
			cmd(4'h0, c[2:0]);
		cmd(4'h1, CMD_SUSPEND);
		cmd(4'h2, CMD_SUSPEND);
		cmd(4'h3, CMD_DISABLE);
		rem.send(pk(6'h09, TYPE_RESUME, 3'h0, 4'h0, 3'h0, 8'h0), 1'b0);
		e_res = e_res | e_sus;
		e_sus = 3'h0;
		quiet("resume quiet");
		`CHK("resumed", e_sus, sus)
		`CHK("resume pulse", e_res, acc_res)
		for (int t = 0; t < 16; t++)
			if (!(t inside {0, 1, 5, 8, 15})) begin
				rem.send(pk(6'h05, t[3:0], 3'h0, 4'h0, 3'h0, 8'h0), 1'b0);
				quiet("unassigned");
			end
		`CHK("state kept", {e_dis, e_sus}, {dis, sus})
		apb(1'b0, ADDR_CONF, 32'h0);
		`CHK("conf kept", 32'h7d2, rd)
		rem.send(pk(6'h05, TYPE_PING, 3'h0, 4'h0, 3'h0, 8'h0) | 32'h400000,
			1'b0);
		quiet("t flag set");
		rem.send(pk(6'h05, TYPE_PING, 3'h0, 4'h0, 3'h0, 8'h0) | 32'h800000,
			1'b0);
		quiet("r flag set");
		rem.send(pk(6'h05, TYPE_PING, 3'h0, 4'h0, 3'h0, 8'h0), 1'b1);
		quiet("bad inverse");
		slow <= 1'b1;
		rem.send(pk(6'h05, TYPE_RD_BASE, 3'h0, 4'h0, 3'h2, 8'h0), 1'b0);
		rem.send(pk(6'h05, TYPE_RD_BASE, 3'h0, 4'h0, 3'h0, 8'h0), 1'b0);
		frame(pk(6'h05, TYPE_RPL_BASE, 3'h0, 4'h0, 3'h2, 8'h03),
			"slow reply");
		quiet("dropped");
		apb(1'b0, ADDR_STAT, 32'h0);
		`CHK("drop flag", 1'b1, rd[STAT_DROP_BIT])
		apb(1'b1, ADDR_STAT, 32'h1000000);
		apb(1'b0, ADDR_STAT, 32'h0);
		`CHK("drop clear", 1'b0, rd[STAT_DROP_BIT])
		tally_and_finish();
	end
endmodule
